// ==== aptf_cmd.v ====
// ATA command interpreter: power query, trim, diagnostic, flushes
`include "aptf_defs.vh"
`default_nettype none
// Function
// [RULE_01] Power query in standby returns count 00h
// [RULE_02] Power query in idle returns FFh
// [RULE_03] Trim count: previous high, current low byte
// [RULE_04] Trim selected by feature bit zero only
// [RULE_05] Host sends one 512-byte range block
// [RULE_06] Diagnostic ignores drive bit, master reports
// [RULE_07] Diagnostic result code into error register
// [RULE_08] Flush reports ready and seek after media write
// [RULE_09] Unsupported flush ends with command aborted
// [RULE_10] Extended flush holds busy until done or error
// [RULE_11] Write error aborts, failing 48-bit address kept
// [RULE_12] Next extended flush resumes after failed sector
// [RULE_13] Finish by requesting register FIS with interrupt
// [RULE_14] Both power query opcodes decode identically
module aptf_cmd (
  input  wire        clk_i,          // 25 MHz clock
  input  wire        resetn_i,       // Async reset, active low
  input  wire        cmd_valid_i,    // Command written, one pulse
  input  wire [7:0]  cmd_op_i,       // Command opcode
  input  wire [7:0]  feat_i,         // Features, current write
  input  wire [7:0]  cnt_cur_i,      // Sector count, current write
  input  wire [7:0]  cnt_prev_i,     // Sector count, previous write
  input  wire [7:0]  dev_head_i,     // Drive/head register
  input  wire        pwr_standby_i,  // In or entering/leaving standby
  input  wire        flush_sup_i,    // Plain flush supported
  input  wire        flush_ext_sup_i,// Extended flush supported
  input  wire        diag_done_i,    // Internal tests finished
  input  wire [7:0]  diag_code_i,    // Test result code
  input  wire        cache_empty_i,  // Write cache holds nothing
  input  wire        wr_done_i,      // Sector committed, one pulse
  input  wire        wr_err_i,       // Unrecoverable write error
  input  wire [47:0] wr_lba_i,       // Sector being written
  input  wire        trim_done_i,    // Trim range processed
  input  wire        fis_ack_i,      // Register FIS transmitted
  output wire        busy_o,         // Status busy
  output wire [7:0]  status_o,       // Status register
  output wire [7:0]  error_o,        // Error register
  output wire [7:0]  seccnt_o,       // Sector count result
  output wire [47:0] lba_o,          // Command block address result
  output wire        diag_start_o,   // Start tests, one pulse
  output wire        flush_go_o,     // Write cache to media
  output wire [47:0] flush_from_o,   // Resume address of flush
  output wire        flush_resume_o, // Resume address valid
  output wire        trim_go_o,      // Run trim of one block
  output wire [15:0] trim_cnt_o,     // Trim block count
  output wire        fis_req_o,      // Send register FIS, I bit set
  output wire        irq_o           // Interrupt with FIS
);
  // One-hot sequencer states
  localparam S_IDLE  = 6'b000001;
  localparam S_DIAG  = 6'b000010;
  localparam S_FLUSH = 6'b000100;
  localparam S_TRIM  = 6'b001000;
  localparam S_FIS   = 6'b010000;
  localparam S_WAIT  = 6'b100000;

  // Reset release through two flops
  reg rst_s1_ff;
  reg rst_s2_ff;
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_s1_ff <= 1'b0;
      rst_s2_ff <= 1'b0;
    end else begin
      rst_s1_ff <= 1'b1;
      rst_s2_ff <= rst_s1_ff;
    end
  end
  wire rst_n = rst_s2_ff;

  // Power query opcode decode
  function is_pwrq;
    input [7:0] op;
    begin
      is_pwrq = (op == `APTF_OP_PWRQ_A) || (op == `APTF_OP_PWRQ_B); // RULE_14
    end
  endfunction

  // Flush opcode decode, plain or extended
  function is_flush;
    input [7:0] op;
    begin
      is_flush = (op == `APTF_OP_FLUSH) || (op == `APTF_OP_FLUSH_EXT);
    end
  endfunction

  // Extended flush opcode decode
  function is_flush_ext;
    input [7:0] op;
    begin
      is_flush_ext = (op == `APTF_OP_FLUSH_EXT);
    end
  endfunction

  // Trim accepted only with its bit and a single block
  function trim_ok;
    input [7:0]  feat;
    input [15:0] cnt;
    begin
      trim_ok = feat[`APTF_FEAT_TRIM] && (cnt == `APTF_TRIM_ONE);
    end
  endfunction

  // Sequencer state and remembered failure
  reg [5:0]  st_ff;
  reg        ext_ff;           // Current flush is the extended one
  reg        fail_vld_ff;      // A failed sector is remembered
  reg [47:0] fail_lba_ff;      // Last sector failed in an extended flush
  // Registered results seen at the outputs
  reg        busy_ff;
  reg [7:0]  status_ff;
  reg [7:0]  error_ff;
  reg [7:0]  seccnt_ff;
  reg [47:0] lba_ff;
  reg        diag_start_ff;
  reg        flush_go_ff;
  reg [47:0] flush_from_ff;
  reg        flush_resume_ff;
  reg        trim_go_ff;
  reg [15:0] trim_cnt_ff;
  reg        fis_req_ff;
  reg        irq_ff;

  // Next values
  reg [5:0]  nxt_st;
  reg        nxt_ext;
  reg        nxt_fail_vld;
  reg [47:0] nxt_fail_lba;
  reg        nxt_busy;
  reg [7:0]  nxt_status;
  reg [7:0]  nxt_error;
  reg [7:0]  nxt_seccnt;
  reg [47:0] nxt_lba;
  reg        nxt_diag_start;
  reg        nxt_flush_go;
  reg [47:0] nxt_flush_from;
  reg        nxt_flush_resume;
  reg        nxt_trim_go;
  reg [15:0] nxt_trim_cnt;
  reg        nxt_fis_req;
  reg        nxt_irq;

  // Paired count and resume address
  wire [15:0] cnt_word   = {cnt_prev_i, cnt_cur_i};      // RULE_03
  wire [47:0] resume_lba = fail_lba_ff + `APTF_LBA_ONE;  // RULE_12

  // Next-state and result logic of the sequencer
  always @* begin
    nxt_st           = st_ff;
    nxt_ext          = ext_ff;
    nxt_fail_vld     = fail_vld_ff;
    nxt_fail_lba     = fail_lba_ff;
    nxt_busy         = busy_ff;
    nxt_status       = status_ff;
    nxt_error        = error_ff;
    nxt_seccnt       = seccnt_ff;
    nxt_lba          = lba_ff;
    nxt_diag_start   = 1'b0;
    nxt_flush_go     = flush_go_ff;
    nxt_flush_from   = flush_from_ff;
    nxt_flush_resume = flush_resume_ff;
    nxt_trim_go      = trim_go_ff;
    nxt_trim_cnt     = trim_cnt_ff;
    nxt_fis_req      = fis_req_ff;
    nxt_irq          = 1'b0;
    case (st_ff)
      S_IDLE: begin
        if (cmd_valid_i) begin
          nxt_busy   = 1'b1;
          nxt_status = `APTF_ST_BUSY_VAL;
          nxt_error  = `APTF_ERR_RST;
          if (is_pwrq(cmd_op_i)) begin
            // Result chosen from current power state
            nxt_seccnt = pwr_standby_i ? `APTF_PWR_STANDBY  // RULE_01
                                       : `APTF_PWR_IDLE;    // RULE_02
            nxt_status = `APTF_ST_IDLE_VAL;
            nxt_st     = S_FIS;
          end else if (cmd_op_i == `APTF_OP_DSM) begin
            // 16-bit count; only trim of one block is run
            nxt_trim_cnt = cnt_word;                        // RULE_03
            if (trim_ok(feat_i, cnt_word)) begin            // RULE_04
              nxt_trim_go = 1'b1;                           // RULE_05
              nxt_st      = S_TRIM;
            end else begin
              nxt_error  = `APTF_ERR_ABRT;
              nxt_status = `APTF_ST_ERR_VAL;
              nxt_st     = S_FIS;
            end
          end else if (cmd_op_i == `APTF_OP_DIAG) begin
            // Drive bit not looked at; tests always run
            nxt_diag_start = 1'b1;                          // RULE_06
            nxt_st         = S_DIAG;
          end else if (is_flush(cmd_op_i)) begin
            nxt_ext = is_flush_ext(cmd_op_i);
            if (is_flush_ext(cmd_op_i) ? !flush_ext_sup_i : !flush_sup_i) begin
              nxt_error  = `APTF_ERR_ABRT;                  // RULE_09
              nxt_status = `APTF_ST_ERR_VAL;
              nxt_st     = S_FIS;
            end else begin
              // Extended flush restarts past the failed sector
              nxt_flush_resume = is_flush_ext(cmd_op_i) &&
                                 fail_vld_ff;               // RULE_12
              nxt_flush_from   = resume_lba;                // RULE_12
              nxt_flush_go     = 1'b1;
              nxt_st           = S_FLUSH;
            end
          end else begin
            // Opcode not handled by this block
            nxt_error  = `APTF_ERR_ABRT;
            nxt_status = `APTF_ST_ERR_VAL;
            nxt_st     = S_FIS;
          end
        end
      end
      S_TRIM: begin
        // Trim runs until its range block is done
        if (trim_done_i) begin
          nxt_trim_go = 1'b0;
          nxt_status  = `APTF_ST_IDLE_VAL;
          nxt_st      = S_FIS;
        end
      end
      S_DIAG: begin
        if (diag_done_i) begin
          nxt_error  = diag_code_i;                         // RULE_07
          nxt_status = (diag_code_i == `APTF_DIAG_OK) ? `APTF_ST_IDLE_VAL
                                                      : `APTF_ST_ERR_VAL;
          nxt_st     = S_FIS;
        end
      end
      S_FLUSH: begin
        // Busy held until cache drained or a write fails
        if (wr_err_i) begin
          nxt_flush_go     = 1'b0;
          nxt_flush_resume = 1'b0;
          nxt_error        = `APTF_ERR_ABRT;                // RULE_11
          nxt_status       = `APTF_ST_ERR_VAL;
          nxt_lba          = wr_lba_i;                      // RULE_11
          nxt_fail_vld     = ext_ff;
          if (ext_ff) begin
            nxt_fail_lba   = wr_lba_i;                      // RULE_12
          end
          nxt_st           = S_FIS;
        end else if (cache_empty_i && !wr_done_i) begin
          nxt_flush_go     = 1'b0;                          // RULE_10
          nxt_flush_resume = 1'b0;
          if (ext_ff) begin
            nxt_fail_vld   = 1'b0;
          end
          nxt_status       = `APTF_ST_IDLE_VAL;             // RULE_08
          nxt_st           = S_FIS;
        end
      end
      S_FIS: begin
        nxt_busy                 = 1'b0;
        nxt_status[`APTF_ST_BSY] = 1'b0;
        nxt_fis_req              = 1'b1;                    // RULE_13
        nxt_irq                  = 1'b1;                    // RULE_13
        nxt_st                   = S_WAIT;
      end
      S_WAIT: begin
        if (fis_ack_i) begin
          nxt_fis_req = 1'b0;
          nxt_st      = S_IDLE;                             // RULE_13
        end
      end
      default: nxt_st = S_IDLE;
    endcase
  end

  // State and result registers
  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      st_ff           <= S_IDLE;
      ext_ff          <= 1'b0;
      fail_vld_ff     <= 1'b0;
      fail_lba_ff     <= `APTF_LBA_RST;
      busy_ff         <= 1'b0;
      status_ff       <= `APTF_ST_RST_VAL;
      error_ff        <= `APTF_ERR_RST;
      seccnt_ff       <= `APTF_CNT_RST;
      lba_ff          <= `APTF_LBA_RST;
      diag_start_ff   <= 1'b0;
      flush_go_ff     <= 1'b0;
      flush_from_ff   <= `APTF_LBA_RST;
      flush_resume_ff <= 1'b0;
      trim_go_ff      <= 1'b0;
      trim_cnt_ff     <= `APTF_TRIM_RST;
      fis_req_ff      <= 1'b0;
      irq_ff          <= 1'b0;
    end else begin
      st_ff           <= nxt_st;
      ext_ff          <= nxt_ext;
      fail_vld_ff     <= nxt_fail_vld;
      fail_lba_ff     <= nxt_fail_lba;
      busy_ff         <= nxt_busy;
      status_ff       <= nxt_status;
      error_ff        <= nxt_error;
      seccnt_ff       <= nxt_seccnt;
      lba_ff          <= nxt_lba;
      diag_start_ff   <= nxt_diag_start;
      flush_go_ff     <= nxt_flush_go;
      flush_from_ff   <= nxt_flush_from;
      flush_resume_ff <= nxt_flush_resume;
      trim_go_ff      <= nxt_trim_go;
      trim_cnt_ff     <= nxt_trim_cnt;
      fis_req_ff      <= nxt_fis_req;
      irq_ff          <= nxt_irq;
    end
  end

  // Outputs straight from the result flops
  assign busy_o         = busy_ff;
  assign status_o       = status_ff;
  assign error_o        = error_ff;
  assign seccnt_o       = seccnt_ff;
  assign lba_o          = lba_ff;
  assign diag_start_o   = diag_start_ff;
  assign flush_go_o     = flush_go_ff;
  assign flush_from_o   = flush_from_ff;
  assign flush_resume_o = flush_resume_ff;
  assign trim_go_o      = trim_go_ff;
  assign trim_cnt_o     = trim_cnt_ff;
  assign fis_req_o      = fis_req_ff;
  assign irq_o          = irq_ff;
endmodule
`default_nettype wire

// ==== aptf_defs.vh ====
// Constants of the ATA power/trim/flush command interpreter
`ifndef APTF_DEFS_VH
`define APTF_DEFS_VH
`define APTF_OP_PWRQ_A    8'h98
`define APTF_OP_PWRQ_B    8'hE5
`define APTF_OP_DSM       8'h06
`define APTF_OP_DIAG      8'h90
`define APTF_OP_FLUSH     8'hE7
`define APTF_OP_FLUSH_EXT 8'hEA
`define APTF_PWR_STANDBY  8'h00
`define APTF_PWR_IDLE     8'hFF
`define APTF_FEAT_TRIM    0
`define APTF_DIAG_OK      8'h01
`define APTF_DIAG_FMT     8'h02
`define APTF_DIAG_BUF     8'h03
`define APTF_DIAG_ECC     8'h04
`define APTF_DIAG_CPU     8'h05
`define APTF_ERR_ABRT     8'h04
`define APTF_ST_BSY       7
`define APTF_ST_RDY       6
`define APTF_ST_DF        5
`define APTF_ST_DSC       4
`define APTF_ST_ERR       0
`define APTF_ST_IDLE_VAL  8'h50
`define APTF_ST_RST_VAL   8'h50
`define APTF_ST_BUSY_VAL  8'h80
`define APTF_ST_ERR_VAL   8'h51
`define APTF_TRIM_ONE     16'h0001
`define APTF_LBA_ONE      48'h000000000001
`define APTF_ERR_RST      8'h00
`define APTF_CNT_RST      8'h00
`define APTF_LBA_RST      48'h000000000000
`define APTF_TRIM_RST     16'h0000
`define APTF_LBA_W        48
`endif

// ==== aptf_host.sv ====
// Host model: acknowledges each register FIS, quickly or late
`default_nettype none
module aptf_host (
  input  wire logic clk_i,     // Clock
  input  wire logic resetn_i,  // Reset, active low
  input  wire logic fis_req_i, // FIS wanted by device
  input  wire logic slow_i,    // Wait five cycles first
  output var  logic fis_ack_o  // FIS sent, one pulse
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] wait_ff;
  // Count the wait, then pulse the acknowledge once
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wait_ff   <= 4'h0;
      fis_ack_o <= 1'b0;
    end else begin
      fis_ack_o <= fis_req_i & ~fis_ack_o & (~slow_i | wait_ff == 4'h5);
      wait_ff   <= (fis_req_i & ~fis_ack_o) ? wait_ff + 4'h1 : 4'h0;
    end
  end
endmodule
`default_nettype wire

// ==== aptf_props.sv ====
// Port checker of the command interpreter
`default_nettype none
module aptf_props (
  input wire logic       clk_i,         // Clock
  input wire logic       resetn_i,      // Reset
  input wire logic       cmd_valid_i,   // Command
  input wire logic [7:0] cmd_op_i,      // Opcode
  input wire logic       pwr_standby_i, // Standby
  input wire logic       flush_sup_i,   // Flush ok
  input wire logic       cache_empty_i, // Drained
  input wire logic       wr_err_i,      // Write error
  input wire logic       fis_ack_i,     // FIS sent
  input wire logic       busy_o,        // Busy
  input wire logic [7:0] status_o,      // Status
  input wire logic [7:0] error_o,       // Error
  input wire logic [7:0] seccnt_o,      // Count
  input wire logic       diag_start_o,  // Test start
  input wire logic       flush_go_o,    // Flushing
  input wire logic       fis_req_o,     // FIS request
  input wire logic       irq_o          // Interrupt
);
  timeunit 1ns;
  timeprecision 1ns;
  // Command taken while idle, and the power query among them
  wire logic take = cmd_valid_i & ~busy_o & ~fis_req_o;
  wire logic pwrq = take & (cmd_op_i == 8'h98 | cmd_op_i == 8'hE5);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!resetn_i);
  AST_PWR_STBY: assert property (
    pwrq & pwr_standby_i |-> ##2 seccnt_o == 8'h00 & fis_req_o & irq_o)
    else $error("query in standby wrong");
  AST_PWR_IDLE: assert property (
    pwrq & ~pwr_standby_i |-> ##2 seccnt_o == 8'hFF & fis_req_o & !busy_o)
    else $error("query in idle wrong");
  AST_FLUSH_BUSY: assert property (
    busy_o & flush_go_o & ~cache_empty_i & ~wr_err_i |=> busy_o)
    else $error("busy dropped with cache full");
  AST_FLUSH_OK: assert property (
    $rose(fis_req_o) & $past(flush_go_o, 2) & ~status_o[0] |->
    status_o[6] & status_o[4]) else $error("flush end status wrong");
  AST_FLUSH_ABORT: assert property (
    take & cmd_op_i == 8'hE7 & ~flush_sup_i |-> ##[1:4]
    fis_req_o & error_o == 8'h04 & status_o[0]) else $error("no abort");
  AST_DIAG_START: assert property (
    take & cmd_op_i == 8'h90 |-> ##[1:3] diag_start_o)
    else $error("tests not started");
  AST_FIS_IRQ: assert property (
    $rose(fis_req_o) |-> irq_o ##1 !irq_o) else $error("irq with FIS wrong");
  AST_FIS_HOLD: assert property (
    fis_req_o & ~fis_ack_i |=> fis_req_o) else $error("FIS request dropped");
endmodule
`default_nettype wire

// ==== tb.sv ====
// Self-checking bench of the command interpreter
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_i = 0, resetn_i = 0, cmd_valid_i = 0, pwr_standby_i = 0;
  logic        flush_sup_i = 1, flush_ext_sup_i = 1, diag_done_i = 0;
  logic        cache_empty_i = 1, wr_done_i = 0, wr_err_i = 0, irq_o;
  logic        trim_done_i = 0, fis_ack_i, slow = 0, err_arm = 0;
  logic [7:0]  cmd_op_i = 0, feat_i = 0, cnt_cur_i = 0, cnt_prev_i = 0;
  logic [7:0]  dev_head_i = 0, diag_code_i = 0, status_o, error_o, seccnt_o;
  logic [47:0] wr_lba_i = 48'h0000_1234_5678, lba_o, flush_from_o;
  logic [15:0] trim_cnt_o;
  logic        busy_o, diag_start_o, flush_go_o, flush_resume_o;
  logic        trim_go_o, fis_req_o;
  int          errors = 0, n_checks = 0, cycles = 0;
  aptf_cmd dut_u (.*);
  aptf_host host_u (.clk_i, .resetn_i, .fis_req_i(fis_req_o), .slow_i(slow),
    .fis_ack_o(fis_ack_i));
  initial begin
    forever #20 clk_i = ~clk_i;
  end
  task automatic check(input string nm, input logic [47:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  task automatic stat(input logic [7:0] st, er);
    check("status", status_o, st);
    check("error", error_o, er);
  endtask
  task automatic go(input logic [7:0] op, ft, input logic [15:0] cnt);
    @(posedge clk_i);
    cmd_valid_i <= 1'b1;
    cmd_op_i <= op;
    feat_i <= ft;
    {cnt_prev_i, cnt_cur_i} <= cnt;
    @(posedge clk_i);
    cmd_valid_i <= 1'b0;
  endtask
  task automatic fin();
    for (int i = 0; i < 40 && !fis_ack_i; i++) @(posedge clk_i);
    if (!fis_ack_i) errors++;
  endtask
  task automatic complete_run();
    if (errors == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Back end: test, trim and write pulses follow the design; timeout
  always @(posedge clk_i) begin
    diag_done_i <= diag_start_o;
    trim_done_i <= trim_go_o & ~trim_done_i;
    wr_done_i <= flush_go_o & ~cache_empty_i;
    wr_err_i <= flush_go_o & err_arm & ~wr_err_i;
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      errors++;
      complete_run();
    end
  end
  initial begin
    repeat (10) @(posedge clk_i);
    resetn_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    // Power query: both opcodes, both states, quick and slow host
    for (int i = 0; i < 4; i++) begin
      pwr_standby_i <= i[0];
      slow <= i[0] ^ i[1];
      go(i[1] ? 8'hE5 : 8'h98, 8'h00, 16'h0000);
      fin();
      check("count", seccnt_o, i[0] ? 8'h00 : 8'hFF);
    end
    // Diagnostic: every result code, either drive bit
    for (int c = 1; c < 6; c++) begin
      diag_code_i <= c[7:0];
      dev_head_i <= {3'h0, c[0], 4'h0};
      go(8'h90, 8'h00, 16'h0000);
      fin();
      stat({7'h28, c != 1}, c[7:0]);
    end
    // Trim of one block, then no trim bit and a wide count
    for (int k = 0; k < 3; k++) begin
      go(8'h06, {7'h00, k != 1}, {7'h00, k == 2, 8'h01});
      fin();
      stat(k ? 8'h51 : 8'h50, k ? 8'h04 : 8'h00);
      check("trim count", trim_cnt_o, {7'h00, k == 2, 8'h01});
    end
    // Both flushes hold busy until drained; unsupported ones abort
    for (int j = 0; j < 4; j++) begin
      flush_sup_i <= j != 2;
      flush_ext_sup_i <= j != 3;
      cache_empty_i <= 1'b0;
      go(j[0] ? 8'hEA : 8'hE7, 8'h00, 16'h0000);
      for (int w = 0; w < 4 && !fis_ack_i; w++) @(posedge clk_i);
      check("busy", busy_o, j < 2);
      cache_empty_i <= 1'b1;
      fin();
      stat(j < 2 ? 8'h50 : 8'h51, j < 2 ? 8'h00 : 8'h04);
    end
    // Extended flush write error, then resume after the failed sector
    cache_empty_i <= 1'b0;
    flush_ext_sup_i <= 1'b1;
    err_arm <= 1'b1;
    go(8'hEA, 8'h00, 16'h0000);
    fin();
    err_arm <= 1'b0;
    stat(8'h51, 8'h04);
    check("lba", lba_o, 48'h0000_1234_5678);
    go(8'hEA, 8'h00, 16'h0000);
    repeat (2) @(posedge clk_i);
    check("from", flush_from_o, 48'h0000_1234_5679);
    check("resume set", flush_resume_o, 1'b1);
    cache_empty_i <= 1'b1;
    fin();
    check("resume", flush_resume_o, 1'b0);
    stat(8'h50, 8'h00);
    complete_run();
  end
endmodule
bind aptf_cmd aptf_props chk_u (.*);
`default_nettype wire
